/* File: common/mvd_pkg.sv */
package mvd_pkg;
  // bus shape
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_CTRL_C = 7'h5d;
  localparam logic [6:0] IDX_EVT_SRC = 7'h5e;
  localparam logic [6:0] IDX_DET_CFG = 7'h69;
  localparam logic [6:0] IDX_THR_HI = 7'h6a;
  localparam logic [6:0] IDX_THR_LO = 7'h6b;
  localparam logic [6:0] IDX_DB_COUNT = 7'h6c;
  localparam logic [6:0] IDX_INIT_BASE = 7'h6d;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // control register fields
  localparam int CC_BYPASS = 7;
  localparam int CC_SLP_OS_HI = 6;
  localparam int CC_SLP_OS_LO = 4;
  localparam int CC_AXIS_UPD = 3;
  localparam int CC_ST_Z = 2;
  localparam int CC_ST_XY_HI = 1;
  // event source fields
  localparam int ES_THS = 2;
  localparam int ES_VECM = 1;
  localparam int ES_DRDY = 0;
  // detector config fields
  localparam int DC_LATCH = 6;
  localparam int DC_INIT_SRC = 5;
  localparam int DC_FREEZE = 4;
  localparam int DC_EN = 3;
  localparam int DC_WAKE = 2;
  localparam int DC_INT_EN = 1;
  localparam int DC_PIN_SEL = 0;
  localparam logic [7:0] DC_MASK = 8'h7f;
  // threshold high byte: debounce mode in bit 7, threshold bits 14:8
  localparam int TH_DB_MODE = 7;
  // output data rate codes, 1.56 Hz up to 800 Hz
  localparam logic [2:0] ODR_800 = 3'h7;
  localparam logic [10:0] DECIM_MIN = 11'h002;
  // exponent bias per rate: factor = 2^(max(os,1)+bias), at least 2
  localparam int ODR_EXP_BIAS [8] = '{3, 1, 0, -2, -3, -4, -5, -6};
endpackage

/* File: core/mvd_detect.sv */
`timescale 1ns/100ps
module mvd_detect
  import mvd_pkg::*;
(
  input  wire logic                      core_clk,         // system clock
  input  wire logic                      sys_rst,          // sync reset
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,     // write address
  input  wire logic                      s_axi_awvalid,    // write addr valid
  output logic                           s_axi_awready,    // write addr ready
  input  wire logic [DATA_W-1:0]         s_axi_wdata,      // write data
  input  wire logic [DATA_W/8-1:0]       s_axi_wstrb,      // byte strobes
  input  wire logic                      s_axi_wvalid,     // write data valid
  output logic                           s_axi_wready,     // write data ready
  output logic [1:0]                     s_axi_bresp,      // write response
  output logic                           s_axi_bvalid,     // response valid
  input  wire logic                      s_axi_bready,     // response ready
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,     // read address
  input  wire logic                      s_axi_arvalid,    // read addr valid
  output logic                           s_axi_arready,    // read addr ready
  output logic [DATA_W-1:0]              s_axi_rdata,      // read data
  output logic [1:0]                     s_axi_rresp,      // read response
  output logic                           s_axi_rvalid,     // read data valid
  input  wire logic                      s_axi_rready,     // read data ready
  input  wire logic                      sampleStrobe,     // new decimated sample
  input  wire logic [2:0][15:0]          rawSample,        // x,y,z raw data
  input  wire logic [2:0][15:0]          hardIronOffset,   // stored offsets
  input  wire logic [2:0]                thsTrigger,       // per-axis ths event
  input  wire logic [2:0]                odrSelect,        // data rate code
  input  wire logic [2:0]                oversampleRatio,  // normal os setting
  input  wire logic                      sleepActive,      // in auto-sleep
  output logic [2:0][15:0]               magOut,           // corrected sample
  output logic                           magOutValid,      // sample pulse
  output logic [10:0]                    decimFactor,      // decimation ratio
  output logic                           zSelftestEnable,  // z stimulus on
  output logic                           xySelftestEnable, // x/y stimulus on
  output logic [2:0]                     thsRefUpdate,     // ths ref refresh
  output logic                           irqLineOne,       // interrupt line 1
  output logic                           irqLineTwo,       // interrupt line 2
  output logic                           vecmWake          // auto-sleep input
);

  typedef struct packed {
    logic              awReady;
    logic              wReady;
    logic              bValid;
    logic [1:0]        bResp;
    logic              awHave;
    logic              wHave;
    logic [6:0]        awIdx;
    logic              awAligned;
    logic [7:0]        wByte;
    logic              wLane;
    logic              arReady;
    logic              rValid;
    logic [1:0]        rResp;
    logic [DATA_W-1:0] rData;
    logic [7:0]        ctrlC;
    logic [7:0]        detCfg;
    logic [7:0]        thrHi;
    logic [7:0]        thrLo;
    logic [7:0]        dbCount;
    logic [2:0][15:0]  initVal;
    logic [2:0][15:0]  refVec;
    logic [2:0][15:0]  magOut;
    logic              magValid;
    logic [7:0]        dbCnt;
    logic              enPrev;
    logic              flagThs;
    logic              flagVecm;
    logic              flagDrdy;
    logic [10:0]       decim;
    logic              stZ;
    logic              stXy;
    logic [2:0]        refUpd;
    logic              irqOne;
    logic              irqTwo;
    logic              wake;
  } mvd_state_t;

  mvd_state_t s;
  mvd_state_t next_s;
  logic       srcRead;

  // true when an index names a register of this block
  function automatic logic isMapped(input logic [6:0] idx);
    return (idx == IDX_CTRL_C) || (idx == IDX_EVT_SRC) ||
           (idx == IDX_DET_CFG) || (idx == IDX_THR_HI) ||
           (idx == IDX_THR_LO) || (idx == IDX_DB_COUNT) ||
           ((idx >= IDX_INIT_BASE) && (idx < IDX_INIT_BASE + 7'h06));
  endfunction

  // decimation lookup, exponent clamped so the factor is never below 2
  function automatic logic [10:0] decimLookup(input logic [2:0] output_data_rate,
                                              input logic [2:0] os);
    int e;
    e = ((os == 3'h0) ? 1 : int'(os)) + ODR_EXP_BIAS[output_data_rate];
    if (e < 1) begin
      e = 1;
    end
    return 11'(11'h001 << e);
  endfunction

  // squared difference of two signed axis values
  function automatic logic [33:0] sqDiff(input logic [15:0] a,
                                         input logic [15:0] b);
    logic signed [16:0] d;
    logic signed [33:0] p;
    d = $signed({a[15], a}) - $signed({b[15], b});
    p = d * d;
    return 34'(p);
  endfunction

  // read of the event source in the cycle the address is taken
  assign srcRead = s.arReady && s_axi_arvalid &&
                   (s_axi_araddr[ADDR_W-1:2] == IDX_EVT_SRC);

  // next-state logic for bus, registers and detector
  always_comb begin
    logic [35:0] distSq;
    logic [29:0] thrSq;
    logic [14:0] thr;
    logic        above;
    logic        hit;
    logic [6:0]  rIdx;
    distSq = '0;
    thrSq = '0;
    thr = '0;
    above = 1'b0;
    hit = 1'b0;
    rIdx = s_axi_araddr[ADDR_W-1:2];
    next_s = s;
    next_s.magValid = 1'b0;
    next_s.refUpd = 3'b000;

    // write address and data taken in either order
    if (s.awReady && s_axi_awvalid) begin
      next_s.awReady = 1'b0;
      next_s.awHave = 1'b1;
      next_s.awIdx = s_axi_awaddr[ADDR_W-1:2];
      next_s.awAligned = (s_axi_awaddr[1:0] == 2'b00);
    end
    if (s.wReady && s_axi_wvalid) begin
      next_s.wReady = 1'b0;
      next_s.wHave = 1'b1;
      next_s.wByte = s_axi_wdata[7:0];
      next_s.wLane = s_axi_wstrb[0];
    end
    if (s.awHave && s.wHave && !s.bValid) begin
      next_s.awHave = 1'b0;
      next_s.wHave = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = (s.awAligned && isMapped(s.awIdx)) ? RESP_OKAY
                                                        : RESP_SLVERR;
      if (s.awAligned && s.wLane) begin
        case (s.awIdx)
          IDX_CTRL_C:   next_s.ctrlC = s.wByte;
          IDX_DET_CFG:  next_s.detCfg = s.wByte & DC_MASK;
          IDX_THR_HI:   next_s.thrHi = s.wByte;
          IDX_THR_LO:   next_s.thrLo = s.wByte;
          IDX_DB_COUNT: next_s.dbCount = s.wByte;
          default: begin
            for (int a = 0; a < 3; a++) begin
              if (s.awIdx == 7'(IDX_INIT_BASE + 2 * a)) begin
                next_s.initVal[a][15:8] = s.wByte;
              end
              if (s.awIdx == 7'(IDX_INIT_BASE + 2 * a + 1)) begin
                next_s.initVal[a][7:0] = s.wByte;
              end
            end
          end
        endcase
      end
    end
    if (s.bValid && s_axi_bready) begin
      next_s.bValid = 1'b0;
      next_s.awReady = 1'b1;
      next_s.wReady = 1'b1;
    end

    // read path; references have no address at all
    if (s.arReady && s_axi_arvalid) begin
      next_s.arReady = 1'b0;
      next_s.rValid = 1'b1;
      next_s.rData = '0;
      next_s.rResp = (s_axi_araddr[1:0] == 2'b00 && isMapped(rIdx))
                     ? RESP_OKAY : RESP_SLVERR;
      case (rIdx)
        IDX_CTRL_C:   next_s.rData[7:0] = s.ctrlC;
        IDX_EVT_SRC:  next_s.rData[7:0] = {5'h00, s.flagThs, s.flagVecm,
                                           s.flagDrdy};
        IDX_DET_CFG:  next_s.rData[7:0] = s.detCfg;
        IDX_THR_HI:   next_s.rData[7:0] = s.thrHi;
        IDX_THR_LO:   next_s.rData[7:0] = s.thrLo;
        IDX_DB_COUNT: next_s.rData[7:0] = s.dbCount;
        default: begin
          for (int a = 0; a < 3; a++) begin
            if (rIdx == 7'(IDX_INIT_BASE + 2 * a)) begin
              next_s.rData[7:0] = s.initVal[a][15:8];
            end
            if (rIdx == 7'(IDX_INIT_BASE + 2 * a + 1)) begin
              next_s.rData[7:0] = s.initVal[a][7:0];
            end
          end
        end
      endcase
    end
    if (s.rValid && s_axi_rready) begin
      next_s.rValid = 1'b0;
      next_s.arReady = 1'b1;
    end

    // reading the event source clears flags; sets below win over this
    if (srcRead) begin
      next_s.flagThs = 1'b0;
      next_s.flagDrdy = 1'b0;
      if (s.detCfg[DC_LATCH]) begin
        next_s.flagVecm = 1'b0;
      end
    end

    // offset correction of each new sample
    if (sampleStrobe) begin
      for (int a = 0; a < 3; a++) begin
        if (s.ctrlC[CC_BYPASS]) begin
          next_s.magOut[a] = rawSample[a];
        end else begin
          next_s.magOut[a] = rawSample[a] - hardIronOffset[a];
        end
      end
      next_s.magValid = 1'b1;
      next_s.flagDrdy = 1'b1;
    end

    // threshold detector reference refresh and flag
    if (thsTrigger != 3'b000) begin
      next_s.flagThs = 1'b1;
      if (s.ctrlC[CC_AXIS_UPD]) begin
        next_s.refUpd = thsTrigger;
      end else begin
        next_s.refUpd = 3'b111;
      end
    end

    // squared distance against squared 15-bit threshold
    thr = {s.thrHi[6:0], s.thrLo};
    thrSq = 30'(thr) * 30'(thr);
    distSq = 36'(sqDiff(s.magOut[0], s.refVec[0])) +
             36'(sqDiff(s.magOut[1], s.refVec[1])) +
             36'(sqDiff(s.magOut[2], s.refVec[2]));
    above = distSq > 36'(thrSq);

    // debounce and event, one step per output sample
    next_s.enPrev = s.detCfg[DC_EN];
    if (!s.detCfg[DC_EN]) begin
      next_s.dbCnt = '0;
      if (!s.detCfg[DC_LATCH]) begin
        next_s.flagVecm = 1'b0;
      end
    end else if (s.magValid) begin
      if (above) begin
        if (s.dbCnt >= s.dbCount) begin
          hit = 1'b1;
        end else begin
          next_s.dbCnt = s.dbCnt + 8'h01;
        end
      end else if (s.thrHi[TH_DB_MODE]) begin
        next_s.dbCnt = '0;
      end else if (s.dbCnt != 8'h00) begin
        next_s.dbCnt = s.dbCnt - 8'h01;
      end
      if (s.detCfg[DC_LATCH]) begin
        if (hit) begin
          next_s.flagVecm = 1'b1;
        end
      end else begin
        next_s.flagVecm = hit;
      end
      if (hit && !s.detCfg[DC_FREEZE]) begin
        next_s.refVec = s.magOut;
        next_s.dbCnt = '0;
      end
    end

    // reference load on enable, or live from init registers
    if (s.detCfg[DC_EN] && !s.enPrev) begin
      next_s.refVec = s.detCfg[DC_INIT_SRC] ? s.initVal : s.magOut;
      next_s.dbCnt = '0;
    end
    if (s.detCfg[DC_EN] && s.detCfg[DC_INIT_SRC] &&
        s.detCfg[DC_FREEZE]) begin
      next_s.refVec = s.initVal;
    end

    // registered control outputs
    next_s.stZ = s.ctrlC[CC_ST_Z];
    next_s.stXy = (s.ctrlC[CC_ST_XY_HI:0] != 2'b00);
    next_s.decim = decimLookup(odrSelect, sleepActive
                   ? s.ctrlC[CC_SLP_OS_HI:CC_SLP_OS_LO]
                   : oversampleRatio);
    next_s.wake = s.detCfg[DC_WAKE] && next_s.flagVecm;
    next_s.irqOne = s.detCfg[DC_INT_EN] && s.detCfg[DC_PIN_SEL] &&
                    next_s.flagVecm;
    next_s.irqTwo = s.detCfg[DC_INT_EN] && !s.detCfg[DC_PIN_SEL] &&
                    next_s.flagVecm;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.awReady <= 1'b1;
      s.wReady <= 1'b1;
      s.arReady <= 1'b1;
      s.ctrlC <= RST_BYTE;
      s.detCfg <= RST_BYTE;
      s.decim <= DECIM_MIN;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign s_axi_awready = s.awReady;
  assign s_axi_wready = s.wReady;
  assign s_axi_bvalid = s.bValid;
  assign s_axi_bresp = s.bResp;
  assign s_axi_arready = s.arReady;
  assign s_axi_rvalid = s.rValid;
  assign s_axi_rresp = s.rResp;
  assign s_axi_rdata = s.rData;
  assign magOut = s.magOut;
  assign magOutValid = s.magValid;
  assign decimFactor = s.decim;
  assign zSelftestEnable = s.stZ;
  assign xySelftestEnable = s.stXy;
  assign thsRefUpdate = s.refUpd;
  assign irqLineOne = s.irqOne;
  assign irqLineTwo = s.irqTwo;
  assign vecmWake = s.wake;

  // checks on the block's own behaviour, core clock and sync reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_OFFSET_APPLY: assert property (
    sampleStrobe && !s.ctrlC[CC_BYPASS] |=>
      magOut[0] == $past(rawSample[0]) - $past(hardIronOffset[0]))
    else $error("offset not applied");
  AST_RAW_BYPASS: assert property (
    sampleStrobe && s.ctrlC[CC_BYPASS] |=>
      magOut == $past(rawSample) && magOutValid)
    else $error("bypass sample differs from raw");
  AST_REF_ALL: assert property (
    thsTrigger != 3'b000 && !s.ctrlC[CC_AXIS_UPD] |=> thsRefUpdate == 3'b111)
    else $error("not all references refreshed");
  AST_REF_AXIS: assert property (
    s.ctrlC[CC_AXIS_UPD] |=> thsRefUpdate == $past(thsTrigger))
    else $error("wrong axis reference refreshed");
  AST_XY_SELFTEST: assert property (
    ##1 xySelftestEnable == ($past(s.ctrlC[CC_ST_XY_HI:0]) != 2'b00))
    else $error("xy self-test mismatch");
  AST_DECIM_800: assert property (
    odrSelect == ODR_800 |=> decimFactor == DECIM_MIN)
    else $error("decimation at top rate not 2");
  AST_THS_FLAG: assert property (
    thsTrigger != 3'b000 |=> s.flagThs)
    else $error("threshold flag not set");
  AST_DRDY_FLAG: assert property (
    sampleStrobe |=> s.flagDrdy ##1 (s.flagDrdy || $past(srcRead)))
    else $error("new-sample flag lost");
  AST_LATCH_HOLD: assert property (
    s.flagVecm && s.detCfg[DC_LATCH] && !srcRead |=> s.flagVecm)
    else $error("latched magnitude flag dropped");
  AST_IRQ_ROUTE: assert property (
    irqLineOne || irqLineTwo |->
      $past(s.detCfg[DC_INT_EN]) && irqLineOne == $past(s.detCfg[DC_PIN_SEL]))
    else $error("magnitude interrupt on wrong line");

endmodule

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import mvd_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic [ADDR_W-1:0]     awAddr = '0, arAddr = '0;
  logic [DATA_W-1:0]     wData = '0, rData;
  logic [3:0]            wStrb = '0;
  logic                  awValid = 0, wValid = 0, bReady = 0;
  logic                  arValid = 0, rReady = 0;
  logic                  awReady, wReady, bValid, arReady, rValid;
  logic [1:0]            bResp, rResp, resp;
  logic                  sampleStrobe = 0, sleepActive = 0;
  logic [2:0][15:0]      rawSample = '0, hardIronOffset = '0, magOut;
  logic [2:0]            thsTrigger = '0, odrSelect = '0, osRatio = '0;
  logic [2:0]            thsRefUpdate;
  logic [10:0]           decimFactor;
  logic                  magOutValid, zSt, xySt, irqOne, irqTwo, vecmWake;
  int                    n_errors = 0;
  int                    comparisons = 0;
  // log2 of the decimation factor, by rate code then oversample setting
  int                    decTab [8][8] = '{
    '{4, 4, 5, 6, 7, 8, 9, 10}, '{2, 2, 3, 4, 5, 6, 7, 8},
    '{1, 1, 2, 3, 4, 5, 6, 7}, '{1, 1, 1, 1, 2, 3, 4, 5},
    '{1, 1, 1, 1, 1, 2, 3, 4}, '{1, 1, 1, 1, 1, 1, 2, 3},
    '{1, 1, 1, 1, 1, 1, 1, 2}, '{1, 1, 1, 1, 1, 1, 1, 1}};

  // half period of the 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  mvd_detect u_mvd_detect (.core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .sampleStrobe(sampleStrobe), .rawSample(rawSample),
    .hardIronOffset(hardIronOffset), .thsTrigger(thsTrigger),
    .odrSelect(odrSelect), .oversampleRatio(osRatio),
    .sleepActive(sleepActive), .magOut(magOut), .magOutValid(magOutValid),
    .decimFactor(decimFactor), .zSelftestEnable(zSt),
    .xySelftestEnable(xySt), .thsRefUpdate(thsRefUpdate),
    .irqLineOne(irqOne), .irqLineTwo(irqTwo), .vecmWake(vecmWake));

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write, address and data offered together
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    int n;
    n = 0;
    awAddr <= a;
    wData <= {24'h000000, v};
    wStrb <= 4'hf;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    do begin
      @(posedge core_clk);
      if (awValid && awReady) awValid <= 0;
      if (wValid && wReady) wValid <= 0;
      n++;
    end while (!(bValid === 1'b1) && n < 50);
    resp = bResp;
    if (n >= 50) check("write answer", 1, 0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    int n;
    n = 0;
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    do begin
      @(posedge core_clk);
      if (arValid && arReady) arValid <= 0;
      n++;
    end while (!(rValid === 1'b1) && n < 50);
    v = rData[7:0];
    resp = rResp;
    if (n >= 50) check("read answer", 1, 0);
    if (rData[31:8] !== 24'h000000) check("rdata upper", 0, rData);
  endtask

  function automatic logic [ADDR_W-1:0] ba(input logic [6:0] idx);
    return {idx, 2'b00};
  endfunction

  // one decimated sample, then time for flag and interrupt to settle
  task automatic smp(input logic [15:0] x);
    @(posedge core_clk);
    sampleStrobe <= 1;
    rawSample <= {16'h0000, 16'h0000, x};
    @(posedge core_clk);
    sampleStrobe <= 0;
    repeat (4) @(posedge core_clk);
  endtask

  // reset values, read-only and refused accesses
  task automatic t_regs();
    logic [7:0] v;
    rd(ba(IDX_CTRL_C), v); check("ctrl reset", 8'h00, v);
    rd(ba(IDX_DET_CFG), v); check("cfg reset", 8'h00, v);
    rd(ba(IDX_EVT_SRC), v); check("evt reset", 8'h00, v);
    wr(ba(IDX_EVT_SRC), 8'h07); check("ro resp", RESP_OKAY, resp);
    rd(ba(IDX_EVT_SRC), v); check("evt ro", 8'h00, v);
    rd(9'h175, v); check("unaligned", RESP_SLVERR, resp);
    rd(9'h000, v); check("unmapped", RESP_SLVERR, resp);
    check("unmapped data", 0, v);
    wr(9'h1fc, 8'h55); check("unmapped wr", RESP_SLVERR, resp);
    $display("test regs done");
  endtask

  // offsets, self-test enables, decimation lookup
  task automatic t_ctrl();
    logic [31:0] e;
    hardIronOffset <= {16'h0007, 16'h0006, 16'h0005};
    wr(ba(IDX_CTRL_C), 8'h00); smp(16'h0100);
    check("offset x", 16'h00fb, magOut[0]);
    check("offset y", 16'hfffa, magOut[1]);
    wr(ba(IDX_CTRL_C), 8'h80); smp(16'h0100);
    check("raw x", 16'h0100, magOut[0]);
    check("raw z", 16'h0000, magOut[2]);
    for (int i = 0; i < 4; i++) begin
      wr(ba(IDX_CTRL_C), 8'h80 | 8'(i));
      repeat (2) @(posedge core_clk);
      check("st z", 0, zSt);
      check("st xy", i != 0, xySt);
    end
    wr(ba(IDX_CTRL_C), 8'h84); repeat (2) @(posedge core_clk);
    check("st z on", 1, zSt);
    for (int r = 0; r < 8; r++) begin
      for (int o = 0; o < 8; o++) begin
        @(posedge core_clk);
        odrSelect <= 3'(r);
        osRatio <= 3'(o);
        repeat (2) @(posedge core_clk);
        e = 1 << decTab[r][o];
        check("decim", e, decimFactor);
      end
    end
    wr(ba(IDX_CTRL_C), 8'hf0);
    sleepActive <= 1;
    osRatio <= 3'h0;
    odrSelect <= 3'h0;
    repeat (3) @(posedge core_clk);
    check("sleep decim", 1024, decimFactor);
    sleepActive <= 0;
    $display("test ctrl done");
  endtask

  // threshold trigger reference refresh and flag
  task automatic t_ths();
    logic [7:0] v;
    for (int m = 0; m < 2; m++) begin
      wr(ba(IDX_CTRL_C), m ? 8'h88 : 8'h80);
      rd(ba(IDX_EVT_SRC), v);
      @(posedge core_clk); thsTrigger <= 3'b010;
      @(posedge core_clk); thsTrigger <= 3'b000;
      @(posedge core_clk);
      check("ref upd", m ? 3'b010 : 3'b111, thsRefUpdate);
      rd(ba(IDX_EVT_SRC), v); check("ths flag", 1, v[ES_THS]);
    end
    rd(ba(IDX_EVT_SRC), v); check("ths clear", 0, v[ES_THS]);
    $display("test ths done");
  endtask

  // magnitude detector, latched then real time
  task automatic t_vecm();
    logic [7:0] v;
    smp(16'h0000);
    wr(ba(IDX_THR_HI), 8'h00); wr(ba(IDX_THR_LO), 8'h0a);
    wr(ba(IDX_DB_COUNT), 8'h02);
    wr(ba(IDX_DET_CFG), 8'h4f);
    rd(ba(IDX_EVT_SRC), v);
    check("drdy", 1, v[ES_DRDY]);
    smp(16'h0064); smp(16'h0064);
    check("early irq", 0, irqOne);
    smp(16'h0064);
    check("irq one", 1, irqOne);
    check("irq two", 0, irqTwo);
    check("wake", 1, vecmWake);
    smp(16'h0064);
    check("latched", 1, irqOne);
    rd(ba(IDX_EVT_SRC), v); check("vecm flag", 8'h03, v);
    repeat (3) @(posedge core_clk);
    check("irq cleared", 0, irqOne);
    wr(ba(IDX_DET_CFG), 8'h0a);
    smp(16'h0078); smp(16'h0078); smp(16'h0078);
    check("rt irq two", 1, irqTwo);
    smp(16'h0078);
    check("rt clear", 0, irqTwo);
    smp(16'h0078); smp(16'h0078);
    check("ref replaced", 0, irqTwo);
    $display("test vecm done");
  endtask

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    check("decim reset", 2, decimFactor);
    t_regs();
    t_ctrl();
    t_ths();
    t_vecm();
    summarize();
  end
endmodule
